// file: design/tppc_cfg.svh
// Address map, reset values and timing constants of the pulse pattern block
`ifndef TPPC_CFG_SVH
`define TPPC_CFG_SVH

`define TPPC_ADDR_MODE      16'hffa0
`define TPPC_ADDR_TRIG      16'hffa1
`define TPPC_ADDR_EN_HI     16'hffa2
`define TPPC_ADDR_EN_LO     16'hffa3
`define TPPC_ADDR_NV_HI     16'hffa4
`define TPPC_ADDR_NV_LO     16'hffa5
`define TPPC_ADDR_NV_HI_ALT 16'hffa6
`define TPPC_ADDR_NV_LO_ALT 16'hffa7
`define TPPC_ADDR_PA_DIR    16'hffd1
`define TPPC_ADDR_PA_VAL    16'hffd3
`define TPPC_ADDR_PB_DIR    16'hffd4
`define TPPC_ADDR_PB_VAL    16'hffd6

`define TPPC_RST_MODE       8'hf0
`define TPPC_RST_TRIG       8'hff
`define TPPC_RST_ZERO       8'h00
`define TPPC_RD_ONES        8'hff
`define TPPC_NIB_ONES       4'hf

`define TPPC_INT_BIT        6
`define TPPC_GROUPS         4
`define TPPC_GUARD_NS       200
`define TPPC_CLK_NS         50
`define TPPC_GUARD_CYC      ((`TPPC_GUARD_NS + `TPPC_CLK_NS - 1) / `TPPC_CLK_NS)

`endif

// file: design/tppc_pkg.sv
// Types shared by the pulse pattern block
package tppc_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } tppc_bus_t;

  typedef enum logic {
    TPPC_IDLE,
    TPPC_GUARD
  } tppc_grp_state_t;

endpackage : tppc_pkg

// file: design/tppc_top.sv
// Pulse pattern controller: next-value staging, triggered copy, port pins
`timescale 1ns/1ns
`default_nettype none
`include "tppc_cfg.svh"

// Function
// - Four 4-bit groups, shared or separate triggers
// - Each bit individually enabled, fifteen usable
// - Per-group trigger from four compare channels
// - Non-overlap mode delays rising edges
// - Bits 0-3,4-7,8-11,12-15 form groups 0-3
// - Bit 14 not driven onto a pin while enabled
// - Port A shares bits 7-0, write-only direction
// - Port B shares bits 15,13-8, direction per pin
// - Enabled port A bits ignore software writes
// - Enabled port B bits ignore software writes
// - Trigger copies low next-values into port A
// - Low next-values clear on reset, hardware standby
// - Shared trigger: low next-values at FFA5 whole
// - Separate: group 0 at FFA7, group 1 FFA5
// - High next-values FFA4, split FFA6/FFA4
// - Shared trigger: FFA7 reads ones, ignores writes
// - Trigger copies high next-values into port B
// - Disabled bits never copied, keep value
module tppc_top
  import tppc_pkg::*;
#(
  parameter int GUARD_CYCLES = `TPPC_GUARD_CYC
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,

  // Register port
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output var  logic [7:0]  rdata_out,

  // Timer compare-match pulses, one per channel
  input  wire logic [3:0]  cmp_match_in,

  // Standby controls
  input  wire logic        hw_standby_in,
  input  wire logic        sw_standby_in,

  // Port A pins
  input  wire logic [7:0]  port_a_pin_in,
  output var  logic [7:0]  port_a_pin_out,
  output var  logic [7:0]  port_a_oe_out,

  // Port B pins
  input  wire logic [7:0]  port_b_pin_in,
  output var  logic [7:0]  port_b_pin_out,
  output var  logic [7:0]  port_b_oe_out,

  // Full internal pattern, bit 14 included
  output var  logic [15:0] pattern_value_out
);

  // Synchronised reset and the bundled bus view
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  tppc_bus_t   bus;

  // Programmer-visible state
  logic [7:0]  mode_q;
  logic [7:0]  trig_q;
  logic [15:0] enable_q;
  logic [15:0] next_q;
  logic [7:0]  pa_dir_q;
  logic [7:0]  pb_dir_q;
  logic [15:0] out_q;

  // Non-overlap guard per group
  tppc_grp_state_t        state_q [`TPPC_GROUPS];
  logic [15:0]            cnt_q   [`TPPC_GROUPS];

  // Trigger decode
  logic [3:0]  trig_hit;
  logic        same_lo;
  logic        same_hi;

  // Reset release through two flops
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  function automatic logic [1:0] grp_sel(input logic [7:0] t,
                                          input int g);
    grp_sel = t[2*g +: 2];
  endfunction : grp_sel

  function automatic logic is_wr(input tppc_bus_t b, input logic [15:0] a);
    is_wr = b.wr && (b.addr == a);
  endfunction : is_wr

  // Merge of pin readback: outputs read their latch, inputs the pin
  function automatic logic [7:0] port_rd(input logic [7:0] dir,
                                         input logic [7:0] val,
                                         input logic [7:0] pin);
    port_rd = (dir & val) | (~dir & pin);
  endfunction : port_rd

  assign same_lo = grp_sel(trig_q, 0) == grp_sel(trig_q, 1);
  assign same_hi = grp_sel(trig_q, 2) == grp_sel(trig_q, 3);

  // Per-group trigger chosen among the channel pulses
  // Software standby masks every trigger, contents stay
  always_comb begin
    for (int g = 0; g < `TPPC_GROUPS; g++) begin
      trig_hit[g] = cmp_match_in[grp_sel(trig_q, g)]
                  && !sw_standby_in;
    end
  end

  // Mode and trigger control
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `TPPC_RST_MODE;
      trig_q <= `TPPC_RST_TRIG;
    end else if (hw_standby_in) begin
      // Hardware standby restores the defaults
      mode_q <= `TPPC_RST_MODE;
      trig_q <= `TPPC_RST_TRIG;
    end else begin
      if (is_wr(bus, `TPPC_ADDR_MODE)) begin
        // Upper mode bits are fixed at one
        mode_q <= {`TPPC_NIB_ONES, bus.wdata[3:0]};
      end
      if (is_wr(bus, `TPPC_ADDR_TRIG)) begin
        trig_q <= bus.wdata;
      end
    end
  end

  // Bit enables
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= {`TPPC_RST_ZERO, `TPPC_RST_ZERO};
    end else if (hw_standby_in) begin
      // Enables fall back too, so no bit stays read-only
      enable_q <= {`TPPC_RST_ZERO, `TPPC_RST_ZERO};
    end else begin
      if (is_wr(bus, `TPPC_ADDR_EN_LO)) begin
        enable_q[7:0] <= bus.wdata;
      end
      if (is_wr(bus, `TPPC_ADDR_EN_HI)) begin
        enable_q[15:8] <= bus.wdata;
      end
    end
  end

  // Next values, address decode depends on trigger sharing
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      next_q <= {`TPPC_RST_ZERO, `TPPC_RST_ZERO};
    end else if (hw_standby_in) begin
      next_q <= {`TPPC_RST_ZERO, `TPPC_RST_ZERO};
    end else begin
      if (is_wr(bus, `TPPC_ADDR_NV_LO)) begin
        if (same_lo) begin
          next_q[7:0] <= bus.wdata;
        end else begin
          next_q[7:4] <= bus.wdata[7:4];
        end
      end
      // Split trigger: group 0 has its own address
      if (is_wr(bus, `TPPC_ADDR_NV_LO_ALT) && !same_lo) begin
        next_q[3:0] <= bus.wdata[3:0];
      end
      if (is_wr(bus, `TPPC_ADDR_NV_HI)) begin
        if (same_hi) begin
          next_q[15:8] <= bus.wdata;
        end else begin
          next_q[15:12] <= bus.wdata[7:4];
        end
      end
      // Split trigger: group 2 has its own address
      if (is_wr(bus, `TPPC_ADDR_NV_HI_ALT) && !same_hi) begin
        next_q[11:8] <= bus.wdata[3:0];
      end
    end
  end

  // Direction registers, write-only
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pa_dir_q <= `TPPC_RST_ZERO;
      pb_dir_q <= `TPPC_RST_ZERO;
    end else begin
      if (is_wr(bus, `TPPC_ADDR_PA_DIR)) begin
        pa_dir_q <= bus.wdata;
      end
      if (is_wr(bus, `TPPC_ADDR_PB_DIR)) begin
        pb_dir_q <= bus.wdata;
      end
    end
  end

  // Non-overlap guard per group: falling bits first, rising after guard
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int g = 0; g < `TPPC_GROUPS; g++) begin
        state_q[g] <= TPPC_IDLE;
        cnt_q[g]   <= 16'h0;
      end
    end else begin
      for (int g = 0; g < `TPPC_GROUPS; g++) begin
        case (state_q[g])
          TPPC_IDLE: begin
            if (trig_hit[g] && mode_q[g]) begin
              state_q[g] <= TPPC_GUARD;
              cnt_q[g]   <= 16'(GUARD_CYCLES - 1);
            end
          end
          TPPC_GUARD: begin
            // Count down the non-overlap margin
            if (cnt_q[g] == 16'h0) begin
              state_q[g] <= TPPC_IDLE;
            end else begin
              cnt_q[g] <= cnt_q[g] - 16'h1;
            end
          end
          default: begin
            state_q[g] <= TPPC_IDLE;
          end
        endcase
      end
    end
  end

  // Port data latches: software writes masked, triggered copies
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= {`TPPC_RST_ZERO, `TPPC_RST_ZERO};
    end else begin
      if (is_wr(bus, `TPPC_ADDR_PA_VAL)) begin
        out_q[7:0] <= (out_q[7:0] & enable_q[7:0])
                    | (bus.wdata & ~enable_q[7:0]);
      end
      if (is_wr(bus, `TPPC_ADDR_PB_VAL)) begin
        out_q[15:8] <= (out_q[15:8] & enable_q[15:8])
                     | (bus.wdata & ~enable_q[15:8]);
      end
      for (int g = 0; g < `TPPC_GROUPS; g++) begin
        // Groups 0-1 land in port A, 2-3 in port B
        if (trig_hit[g] && !mode_q[g]) begin
          for (int b = 4*g; b < 4*g + 4; b++) begin
            if (enable_q[b]) begin
              out_q[b] <= next_q[b];
            end
          end
        end else if (trig_hit[g] && state_q[g] == TPPC_IDLE) begin
          // Non-overlap: only the falling bits move now
          for (int b = 4*g; b < 4*g + 4; b++) begin
            if (enable_q[b] && !next_q[b]) begin
              out_q[b] <= 1'b0;
            end
          end
        end else if (state_q[g] == TPPC_GUARD && cnt_q[g] == 16'h0) begin
          // Guard expired: the rising bits follow
          for (int b = 4*g; b < 4*g + 4; b++) begin
            if (enable_q[b]) begin
              out_q[b] <= next_q[b];
            end
          end
        end
      end
    end
  end

  // Port A pins follow the latch one cycle later
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      port_a_pin_out <= `TPPC_RST_ZERO;
      port_a_oe_out  <= `TPPC_RST_ZERO;
    end else begin
      port_a_pin_out <= out_q[7:0];
      port_a_oe_out  <= pa_dir_q;
    end
  end

  // Port B pins; bit 14 stays internal when in pattern use
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      port_b_pin_out <= `TPPC_RST_ZERO;
      port_b_oe_out  <= `TPPC_RST_ZERO;
    end else begin
      port_b_pin_out <= out_q[15:8];
      port_b_oe_out  <= pb_dir_q;
      if (enable_q[8 + `TPPC_INT_BIT]) begin
        port_b_pin_out[`TPPC_INT_BIT] <= 1'b0;
        port_b_oe_out[`TPPC_INT_BIT]  <= 1'b0;
      end
    end
  end

  // Full pattern view, bit 14 included
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pattern_value_out <= {`TPPC_RST_ZERO, `TPPC_RST_ZERO};
    end else begin
      pattern_value_out <= out_q;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= `TPPC_RST_ZERO;
    end else if (bus.rd) begin
      case (bus.addr)
        `TPPC_ADDR_MODE: begin
          rdata_out <= mode_q;
        end
        `TPPC_ADDR_TRIG: begin
          rdata_out <= trig_q;
        end
        `TPPC_ADDR_EN_HI: begin
          rdata_out <= enable_q[15:8];
        end
        `TPPC_ADDR_EN_LO: begin
          rdata_out <= enable_q[7:0];
        end
        // Next values: reserved nibbles read as ones
        `TPPC_ADDR_NV_LO: begin
          rdata_out <= same_lo ? next_q[7:0]
                               : {next_q[7:4], `TPPC_NIB_ONES};
        end
        `TPPC_ADDR_NV_LO_ALT: begin
          rdata_out <= same_lo ? `TPPC_RD_ONES
                               : {`TPPC_NIB_ONES, next_q[3:0]};
        end
        `TPPC_ADDR_NV_HI: begin
          rdata_out <= same_hi ? next_q[15:8]
                               : {next_q[15:12], `TPPC_NIB_ONES};
        end
        `TPPC_ADDR_NV_HI_ALT: begin
          rdata_out <= same_hi ? `TPPC_RD_ONES
                               : {`TPPC_NIB_ONES, next_q[11:8]};
        end
        // Direction registers are write-only, read as ones
        `TPPC_ADDR_PA_DIR: begin
          rdata_out <= `TPPC_RD_ONES;
        end
        `TPPC_ADDR_PB_DIR: begin
          rdata_out <= `TPPC_RD_ONES;
        end
        `TPPC_ADDR_PA_VAL: begin
          rdata_out <= port_rd(pa_dir_q, out_q[7:0], port_a_pin_in);
        end
        `TPPC_ADDR_PB_VAL: begin
          rdata_out <= port_rd(pb_dir_q, out_q[15:8], port_b_pin_in);
        end
        default:           rdata_out <= `TPPC_RST_ZERO;
      endcase
    end
  end

endmodule : tppc_top
`default_nettype wire

// file: testbench/tppc_top_sva.sv
// Port-level assertions for the pulse pattern block
`timescale 1ns/1ns
`default_nettype none
module tppc_top_sva #(
  parameter int GUARD_CYCLES = 4
) (
  // Clock, reset and register port
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  // Triggers and standby
  input wire logic [3:0]  cmp_match_in,
  input wire logic        hw_standby_in,
  // Pins and pattern
  input wire logic [7:0]  port_a_pin_out,
  input wire logic [7:0]  port_b_pin_out,
  input wire logic [7:0]  port_b_oe_out,
  input wire logic [15:0] pattern_value_out
);
  logic [7:0] trig_q;
  logic [7:0] quiet_q;
  logic       en14_q;
  wire        sh01 = trig_q[1:0] == trig_q[3:2];
  wire        sh23 = trig_q[5:4] == trig_q[7:6];

  always_ff @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in) trig_q <= 8'hff;
    else if (hw_standby_in) trig_q <= 8'hff;
    else if (wr_in && addr_in == 16'hffa1) trig_q <= wdata_in;

  always_ff @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in) en14_q <= 1'b0;
    else if (hw_standby_in) en14_q <= 1'b0;
    else if (wr_in && addr_in == 16'hffa2) en14_q <= wdata_in[6];

  // Cycles since anything that may move the pattern
  always_ff @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in) quiet_q <= 8'h00;
    else if (wr_in || hw_standby_in || |cmp_match_in) quiet_q <= 8'h00;
    else if (quiet_q != 8'hff) quiet_q <= quiet_q + 8'h01;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  property p_hide14;
    en14_q && $past(en14_q) |-> !port_b_oe_out[6] && !port_b_pin_out[6];
  endproperty
  a_hide14: assert property (p_hide14) else $error("bit 14 driven");
  property p_rsv01;
    rd_in && addr_in == 16'hffa7 && sh01 |=> rdata_out == 8'hff;
  endproperty
  a_rsv01: assert property (p_rsv01) else $error("ffa7 not ones");
  property p_rsv23;
    rd_in && addr_in == 16'hffa6 && sh23 |=> rdata_out == 8'hff;
  endproperty
  a_rsv23: assert property (p_rsv23) else $error("ffa6 not ones");
  property p_dira; rd_in && addr_in == 16'hffd1 |=> rdata_out == 8'hff;
  endproperty
  a_dira: assert property (p_dira) else $error("port a dir readable");
  property p_dirb; rd_in && addr_in == 16'hffd4 |=> rdata_out == 8'hff;
  endproperty
  a_dirb: assert property (p_dirb) else $error("port b dir readable");
  property p_hold;
    quiet_q > 8'(GUARD_CYCLES + 3) |-> $stable(pattern_value_out);
  endproperty
  a_hold: assert property (p_hold) else $error("pattern moved");
  property p_mapa; port_a_pin_out == pattern_value_out[7:0]; endproperty
  a_mapa: assert property (p_mapa) else $error("port a mapping");
  property p_mapb; {port_b_pin_out[7], port_b_pin_out[5:0]} ==
    {pattern_value_out[15], pattern_value_out[13:8]}; endproperty
  a_mapb: assert property (p_mapb) else $error("port b mapping");
endmodule : tppc_top_sva

bind tppc_top tppc_top_sva #(.GUARD_CYCLES(GUARD_CYCLES)) i_tppc_top_sva (
  .clock_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .cmp_match_in, .hw_standby_in, .port_a_pin_out, .port_b_pin_out,
  .port_b_oe_out, .pattern_value_out);
`default_nettype wire

// file: testbench/tppc_pin_model.sv
// Board-side model of what hangs on the two pattern ports
`timescale 1ns/1ns
`default_nettype none
module tppc_pin_model (
  // Clock
  input  wire logic       clock_in,
  // Drive and enable from the block
  input  wire logic [7:0] a_out_in,
  input  wire logic [7:0] a_oe_in,
  input  wire logic [7:0] b_out_in,
  input  wire logic [7:0] b_oe_in,
  // Levels back to the block
  output var  logic [7:0] a_pin_out,
  output var  logic [7:0] b_pin_out
);
  logic [15:0] float_q = 16'h5a3c;
  // Released pins float, so show a level that moves every cycle
  always_ff @(posedge clock_in) float_q <= ~{float_q[14:0], float_q[15]};
  assign a_pin_out = (a_oe_in & a_out_in) | (~a_oe_in & float_q[7:0]);
  assign b_pin_out = (b_oe_in & b_out_in) | (~b_oe_in & float_q[15:8]);
endmodule : tppc_pin_model
`default_nettype wire

// file: testbench/test_tppc_top.sv
// Self-checking bench for the pulse pattern block
`timescale 1ns/1ns
`default_nettype none
`define CHECK_EQ(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  fail_count++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module test_tppc_top;
  logic        clock_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic        hw_standby_in = 1'b0, sw_standby_in = 1'b0;
  logic [15:0] addr_in = 16'h0000, pattern_value_out, nv, en, pd, sw;
  logic [7:0]  wdata_in = 8'h00, rdata_out, a_pin, a_out, a_oe;
  logic [7:0]  b_pin, b_out, b_oe;
  logic [3:0]  cmp_match_in = 4'h0, m;
  logic [1:0]  ch;
  int          fail_count = 0, cmp_count = 0;
  logic [15:0] ra [8] = '{16'hffa0, 16'hffa3, 16'hffa5, 16'hffa1, 16'hffa7,
                          16'hffa6, 16'hffd1, 16'hffa8};
  logic [7:0]  rv [8] = '{8'hf0, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff,
                          8'h00};
  logic [15:0] sa [4] = '{16'hffa7, 16'hffa5, 16'hffa6, 16'hffa4};

  tppc_top #(.GUARD_CYCLES(2)) i_tppc_top (.clock_in, .rst_n_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .cmp_match_in, .hw_standby_in,
    .sw_standby_in, .port_a_pin_in(a_pin), .port_a_pin_out(a_out),
    .port_a_oe_out(a_oe), .port_b_pin_in(b_pin), .port_b_pin_out(b_out),
    .port_b_oe_out(b_oe), .pattern_value_out);
  tppc_pin_model i_tppc_pin_model (.clock_in, .a_out_in(a_out), .a_oe_in(a_oe),
    .b_out_in(b_out), .b_oe_in(b_oe), .a_pin_out(a_pin), .b_pin_out(b_pin));

  initial forever #25 clock_in = ~clock_in;

  function automatic logic [15:0] merge(input logic [15:0] e, n, o);
    return (e & n) | (~e & o);
  endfunction : merge

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] ex);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 `CHECK_EQ("rdata", ex, rdata_out)
  endtask : rd

  task automatic trig(input logic [3:0] t);
    @(posedge clock_in);
    cmp_match_in <= t;
    @(posedge clock_in);
    cmp_match_in <= 4'h0;
    repeat (2) @(posedge clock_in);
    #1;
  endtask : trig

  task automatic pins(input logic [15:0] p);
    `CHECK_EQ("pattern", p, pattern_value_out)
    `CHECK_EQ("port a", p[7:0], a_out)
    `CHECK_EQ("port b", {p[15], en[14] ? 1'b0 : p[14], p[13:8]}, b_out)
    if (en[14]) `CHECK_EQ("oe 14", 1'b0, b_oe[6])
    `CHECK_EQ("oe a", 8'hff, a_oe)
    `CHECK_EQ("oe b", {1'b1, ~en[14], 6'h3f}, b_oe)
  endtask : pins

  task automatic finish_test();
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h1e54));
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(16'hffa7, 8'h00);
    rd(16'hffa7, 8'hff);
    wr(16'hffd1, 8'hff);
    wr(16'hffd4, 8'hff);
    rd(16'hffd4, 8'hff);
    pd = 16'h0000;
    for (int i = 0; i < 24; i++) begin
      en = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      nv = 16'($urandom);
      sw = 16'($urandom);
      ch = 2'($urandom);
      m = (i < 4) ? 4'h1 << i : 4'($urandom);
      wr(16'hffa1, {4{ch}});
      wr(16'hffa3, en[7:0]);
      wr(16'hffa2, en[15:8]);
      wr(16'hffa5, nv[7:0]);
      wr(16'hffa4, nv[15:8]);
      wr(16'hffd3, sw[7:0]);
      wr(16'hffd6, sw[15:8]);
      pd = merge(~en, sw, pd);
      rd(16'hffa5, nv[7:0]);
      rd(16'hffd3, pd[7:0]);
      rd(16'hffd6, pd[15:8]);
      trig(m);
      if (m[ch]) pd = merge(en, nv, pd);
      pins(pd);
    end
    // Each group on its own channel
    wr(16'hffa1, 8'he4);
    wr(16'hffa3, 8'hff);
    wr(16'hffa2, 8'hbf);
    en = 16'hbfff;
    nv = 16'($urandom);
    foreach (sa[i]) wr(sa[i], i[1] ? nv[15:8] : nv[7:0]);
    rd(16'hffa7, {4'hf, nv[3:0]});
    rd(16'hffa5, {nv[7:4], 4'hf});
    rd(16'hffa6, {4'hf, nv[11:8]});
    rd(16'hffa4, {nv[15:12], 4'hf});
    for (int g = 0; g < 4; g++) begin
      trig(4'h1 << g);
      pd = merge(en & (16'hf << 4 * g), nv, pd);
      pins(pd);
    end
    // Non-overlap on group 0: falling bits first, rising after the guard
    wr(16'hffa0, 8'h01);
    rd(16'hffa0, 8'hf1);
    nv[3:0] = pd[3:0] ^ 4'h5;
    wr(16'hffa7, {4'h0, nv[3:0]});
    @(posedge clock_in) cmp_match_in <= 4'h1;
    @(posedge clock_in) cmp_match_in <= 4'h0;
    @(posedge clock_in) #1;
    `CHECK_EQ("gap", pd[3:0] & nv[3:0], pattern_value_out[3:0])
    repeat (3) @(posedge clock_in);
    #1 `CHECK_EQ("after gap", nv[3:0], pattern_value_out[3:0])
    pd[3:0] = nv[3:0];
    // Software standby ignores triggers, hardware standby clears
    nv = ~pd;
    wr(16'hffa5, nv[7:0]);
    @(posedge clock_in) sw_standby_in <= 1'b1;
    trig(4'h2);
    pins(pd);
    @(posedge clock_in) sw_standby_in <= 1'b0;
    rd(16'hffa5, {nv[7:4], 4'hf});
    @(posedge clock_in) hw_standby_in <= 1'b1;
    @(posedge clock_in) hw_standby_in <= 1'b0;
    foreach (ra[i]) if (i < 3) rd(ra[i], rv[i]);
    finish_test();
  end
endmodule : test_tppc_top
`default_nettype wire
